// [design/hsl_lane_regs.svh]
`ifndef HSL_LANE_REGS_SVH
`define HSL_LANE_REGS_SVH
// register byte offsets
`define HSL_CTRL_OFS 4'h0
`define HSL_STATUS_OFS 4'h4
`define HSL_DELAY_OFS 4'h8
// control field positions
`define HSL_CTRL_WIDTH_LSB 0
`define HSL_CTRL_REFCLK_BIT 4
`define HSL_CTRL_ALIGN_BIT 5
`define HSL_CTRL_QUEUE_BIT 6
`define HSL_CTRL_HALF_BIT 7
`define HSL_CTRL_MIPI_BIT 8
`define HSL_CTRL_FAST_BIT 9
`define HSL_CTRL_CLKLANE_BIT 10
`define HSL_CTRL_TERMDYN_BIT 11
// status field positions
`define HSL_STAT_LOCK_BIT 0
`define HSL_STAT_VACANT_BIT 1
`define HSL_STAT_FULL_BIT 2
`define HSL_STAT_REPORT_LSB 8
// reset values and counts
`define HSL_CTRL_RESET 12'h008
`define HSL_MAX_WIDTH 10
`define HSL_MIPI_WIDTH 4'h8
`define HSL_QUEUE_DEPTH 8
`define HSL_GOOD_WORDS 4
`define HSL_DELAY_MAX 6'h3f
`endif

// [design/hsl_pkg.sv]
package hsl_pkg;
	typedef enum logic [1:0]
	{
		ALIGN_IDLE = 2'b00,
		ALIGN_SCAN = 2'b01,
		ALIGN_LOCK = 2'b11
	} hsl_align_e;
	typedef logic [5:0] hsl_delay_t;
endpackage

// [design/hsl_lane.sv]
`timescale 1ns/1ps
`include "hsl_lane_regs.svh"
module hsl_lane
#(
	parameter int MAX_WIDTH = `HSL_MAX_WIDTH,
	parameter int QUEUE_DEPTH = `HSL_QUEUE_DEPTH,
	parameter int GOOD_WORDS = `HSL_GOOD_WORDS
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic [MAX_WIDTH-1:0] txWord,
	input wire logic txPathClear,
	input wire logic driveOn,
	output logic serialOut,
	output logic serialOutN,
	output logic serialOe,
	input wire logic serialIn,
	input wire logic rxBufferOn,
	input wire logic termControl,
	output logic termEnable,
	input wire logic rxPathClear,
	output logic [MAX_WIDTH-1:0] rxWord,
	input wire logic delayAdjustOn,
	input wire logic delayDirection,
	input wire logic delayClear,
	output logic alignLocked,
	output hsl_pkg::hsl_delay_t alignDelayReport,
	input wire logic queueRead,
	output logic [MAX_WIDTH-1:0] queueData,
	output logic queueVacant,
	output logic wordTick,
	output logic bitTick,
	output logic bitClockOut
);
	import hsl_pkg::*;
	localparam int PW = $clog2(QUEUE_DEPTH);

	logic [11:0] ctrl_reg;
	logic [3:0] bitCnt_reg;
	logic [3:0] widthEff;
	logic [MAX_WIDTH-1:0] widthMask;
	logic [MAX_WIDTH-1:0] txShift_reg;
	logic [MAX_WIDTH-1:0] rxShift_reg;
	logic [MAX_WIDTH-1:0] rxWord_reg;
	logic [8:0] hist_reg;
	logic sampleIn;
	logic lastIn_reg;
	logic delayedBit;
	logic edgeSeen_reg;
	logic edgeNow;
	hsl_delay_t delay_reg;
	hsl_delay_t report_reg;
	hsl_align_e align_reg;
	logic [3:0] good_reg;
	logic [MAX_WIDTH-1:0] queueMem [QUEUE_DEPTH];
	logic [PW:0] wrPtr_reg;
	logic [PW:0] rdPtr_reg;
	logic [MAX_WIDTH-1:0] queueData_reg;
	logic queueFull;
	logic queuePush;
	logic rxValid;
	logic bitClk_reg;
	logic wordDone_reg;
	logic [31:0] rdData_reg;

	wire refClkMode = ctrl_reg[`HSL_CTRL_REFCLK_BIT];
	wire autoAlign = ctrl_reg[`HSL_CTRL_ALIGN_BIT];
	wire queueOn = ctrl_reg[`HSL_CTRL_QUEUE_BIT];
	wire halfRate = ctrl_reg[`HSL_CTRL_HALF_BIT];
	wire mipiLane = ctrl_reg[`HSL_CTRL_MIPI_BIT];
	wire mipiFast = ctrl_reg[`HSL_CTRL_FAST_BIT];
	wire clockLane = ctrl_reg[`HSL_CTRL_CLKLANE_BIT];
	wire termDynamic = ctrl_reg[`HSL_CTRL_TERMDYN_BIT];

	// configuration writes
	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_reg <= `HSL_CTRL_RESET;
		else if (regWr && regAddr == `HSL_CTRL_OFS)
			ctrl_reg <= regWrData[11:0];
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset || !regRd)
			rdData_reg <= 32'h0;
		else
			case (regAddr)
				`HSL_CTRL_OFS: rdData_reg <= {20'h0, ctrl_reg};
				`HSL_STATUS_OFS: rdData_reg <= {18'h0, report_reg,
					5'h0, queueFull, queueVacant, alignLocked};
				`HSL_DELAY_OFS: rdData_reg <= {26'h0, delay_reg};
				default: rdData_reg <= 32'h0;
			endcase
	end
	assign regRdData = rdData_reg;

	always_comb
	begin
		widthEff = ctrl_reg[3:0];
		if (mipiLane)
			widthEff = mipiFast ? `HSL_MIPI_WIDTH : 4'h1;
		else if (widthEff == 4'h0 || widthEff > 4'(MAX_WIDTH))
			widthEff = 4'(MAX_WIDTH);
	end

	// only the low widthEff bits are live
	generate
		for (genvar i = 0; i < MAX_WIDTH; i++)
		begin : g_mask
			assign widthMask[i] = (i < widthEff);
		end
	endgenerate

	// a switched-off input buffer reads as idle
	assign sampleIn = rxBufferOn & serialIn;
	// termination follows the control only in dynamic mode
	assign termEnable = termDynamic ? termControl : 1'b1;

	always_ff @(posedge clk)
	begin
		if (reset)
			lastIn_reg <= 1'b0;
		else
			lastIn_reg <= sampleIn;
	end

	// a clock lane steps on rising edges of the incoming clock
	assign bitTick = (mipiLane && clockLane) ? (sampleIn & ~lastIn_reg)
		: 1'b1;
	// one word tick every widthEff bits
	assign wordTick = bitTick && (bitCnt_reg >= widthEff - 4'h1);

	// word timing from one divider that counts bit ticks
	always_ff @(posedge clk)
	begin
		if (reset)
			bitCnt_reg <= 4'h0;
		else if (wordTick)
			bitCnt_reg <= 4'h0;
		else if (bitTick)
			bitCnt_reg <= bitCnt_reg + 4'h1;
	end

	// half rate toggles per bit, full rate pulses per bit
	always_ff @(posedge clk)
	begin
		if (reset)
			bitClk_reg <= 1'b0;
		else if (!bitTick)
			bitClk_reg <= halfRate ? bitClk_reg : 1'b0;
		else
			bitClk_reg <= halfRate ? ~bitClk_reg : 1'b1;
	end
	assign bitClockOut = bitClk_reg;

	// load masked word, shift out lsb first
	always_ff @(posedge clk)
	begin
		if (reset || txPathClear)
			txShift_reg <= '0;
		// reference clock sends ones then zeros
		else if (wordTick && refClkMode)
			txShift_reg <= widthMask >> (widthEff - (widthEff >> 1));
		else if (wordTick)
			txShift_reg <= txWord & widthMask;
		else if (bitTick)
			txShift_reg <= txShift_reg >> 1;
	end

	// slow signaling passes the fabric bit straight through
	assign serialOut = (mipiLane && !mipiFast) ? txWord[0] : txShift_reg[0];
	assign serialOutN = ~serialOut;
	// pad driven only while drive-on is high
	assign serialOe = driveOn;

	// sample history acts as the delay chain
	always_ff @(posedge clk)
	begin
		if (reset)
			hist_reg <= 9'h0;
		else if (bitTick)
			hist_reg <= {hist_reg[7:0], sampleIn};
	end
	assign delayedBit = hist_reg[delay_reg[2:0]];
	assign edgeNow = delayedBit != hist_reg[4'(delay_reg[2:0]) + 4'h1];

	always_ff @(posedge clk)
	begin
		if (reset || wordTick)
			edgeSeen_reg <= 1'b0;
		else if (bitTick && edgeNow)
			edgeSeen_reg <= 1'b1;
	end

	// clear resets the counter; enable gates manual steps and starts the scan
	always_ff @(posedge clk)
	begin
		if (reset || delayClear)
			delay_reg <= '0;
		else if (!autoAlign && delayAdjustOn && wordTick)
		begin
			if (delayDirection && delay_reg != `HSL_DELAY_MAX)
				delay_reg <= delay_reg + 6'h1;
			else if (!delayDirection && delay_reg != 6'h0)
				delay_reg <= delay_reg - 6'h1;
		end
		else if (align_reg == ALIGN_SCAN && wordTick
			&& (edgeSeen_reg || edgeNow))
			delay_reg <= delay_reg + 6'h1;
	end

	// scan until enough clean words, then lock
	always_ff @(posedge clk)
	begin
		if (reset || delayClear || !autoAlign)
		begin
			align_reg <= ALIGN_IDLE;
			good_reg <= 4'h0;
		end
		else
			case (align_reg)
				ALIGN_IDLE:
					if (delayAdjustOn)
						align_reg <= ALIGN_SCAN;
				ALIGN_SCAN:
					if (wordTick)
					begin
						if (edgeSeen_reg || edgeNow)
							good_reg <= 4'h0;
						else if (good_reg == 4'(GOOD_WORDS - 1))
							align_reg <= ALIGN_LOCK;
						else
							good_reg <= good_reg + 4'h1;
					end
				ALIGN_LOCK: align_reg <= ALIGN_LOCK;
				default: align_reg <= ALIGN_IDLE;
			endcase
	end
	assign alignLocked = align_reg == ALIGN_LOCK;

	always_ff @(posedge clk)
	begin
		if (reset || delayClear)
			report_reg <= '0;
		else if (align_reg == ALIGN_SCAN && wordTick && !edgeSeen_reg
			&& !edgeNow && good_reg == 4'(GOOD_WORDS - 1))
			report_reg <= delay_reg;
	end
	assign alignDelayReport = report_reg;

	// deserialize, newest bit at the top of the word
	always_ff @(posedge clk)
	begin
		if (reset || rxPathClear)
		begin
			rxShift_reg <= '0;
			rxWord_reg <= '0;
		end
		else if (bitTick)
		begin
			rxShift_reg <= {delayedBit, rxShift_reg[MAX_WIDTH-1:1]};
			if (wordTick)
				rxWord_reg <= ({delayedBit, rxShift_reg[MAX_WIDTH-1:1]}
					>> (4'(MAX_WIDTH) - widthEff)) & widthMask;
		end
	end
	assign rxWord = rxWord_reg;
	assign rxValid = !autoAlign || alignLocked;

	assign queueFull = (wrPtr_reg[PW] != rdPtr_reg[PW])
		&& (wrPtr_reg[PW-1:0] == rdPtr_reg[PW-1:0]);
	// vacant whenever no word is held
	assign queueVacant = wrPtr_reg == rdPtr_reg;
	assign queuePush = queueOn && rxValid && !queueFull && wordDone_reg
		&& !rxPathClear;

	// push the word in the cycle after it lands in rxWord_reg
	always_ff @(posedge clk)
	begin
		if (reset || rxPathClear)
			wordDone_reg <= 1'b0;
		else
			wordDone_reg <= wordTick;
	end

	always_ff @(posedge clk)
	begin
		if (queuePush)
			queueMem[wrPtr_reg[PW-1:0]] <= rxWord_reg;
	end

	always_ff @(posedge clk)
	begin
		if (reset || rxPathClear)
			wrPtr_reg <= '0;
		else if (queuePush)
			wrPtr_reg <= wrPtr_reg + 1'b1;
	end

	// the queue advances only on a read request
	always_ff @(posedge clk)
	begin
		if (reset || rxPathClear)
		begin
			rdPtr_reg <= '0;
			queueData_reg <= '0;
		end
		else if (queueRead && !queueVacant)
		begin
			queueData_reg <= queueMem[rdPtr_reg[PW-1:0]];
			rdPtr_reg <= rdPtr_reg + 1'b1;
		end
	end
	assign queueData = queueData_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_txLoad;
		wordTick && !txPathClear && !refClkMode
			|=> txShift_reg == ($past(txWord) & $past(widthMask));
	endproperty
	a_txLoad: assert property (p_txLoad)
		else $error("transmit word not loaded");

	property p_txClear;
		txPathClear |=> txShift_reg == '0
			&& (rxWord == $past(rxWord) || $past(wordTick));
	endproperty
	a_txClear: assert property (p_txClear)
		else $error("transmit clear failed");

	property p_rxUpper;
		wordTick && !rxPathClear
			|=> (rxWord & ~widthMask) == '0 || $changed(widthEff);
	endproperty
	a_rxUpper: assert property (p_rxUpper)
		else $error("unused receive bits not zero");

	property p_vacant;
		rxPathClear |=> queueVacant;
	endproperty
	a_vacant: assert property (p_vacant)
		else $error("receive clear left queue filled");

	property p_noPop;
		!queueRead && !rxPathClear |=> $stable(rdPtr_reg)
			&& $stable(queueData);
	endproperty
	a_noPop: assert property (p_noPop)
		else $error("queue advanced without request");

	property p_manualInc;
		!autoAlign && delayAdjustOn && delayDirection && wordTick
			&& !delayClear && delay_reg != `HSL_DELAY_MAX
			|=> delay_reg == $past(delay_reg) + 6'h1;
	endproperty
	a_manualInc: assert property (p_manualInc)
		else $error("delay did not increment");

	property p_delayClear;
		delayClear |=> delay_reg == '0 && !alignLocked;
	endproperty
	a_delayClear: assert property (p_delayClear)
		else $error("delay clear failed");

	property p_report;
		$rose(alignLocked) |-> alignDelayReport == delay_reg;
	endproperty
	a_report: assert property (p_report)
		else $error("lock report mismatch");

	property p_mipiWidth;
		mipiLane && mipiFast && !clockLane && wordTick |=> !wordTick [*7];
	endproperty
	a_mipiWidth: assert property (p_mipiWidth)
		else $error("mipi word not eight bits");

	property p_vacantFlag;
		queuePush && queueVacant |=> !queueVacant;
	endproperty
	a_vacantFlag: assert property (p_vacantFlag)
		else $error("vacant flag stuck");

	c_lock: cover property (@(posedge clk) $rose(alignLocked));
	c_full: cover property (@(posedge clk) queueFull);
	c_refClk: cover property (@(posedge clk) wordTick && refClkMode);
	c_pop: cover property (@(posedge clk) queueRead && !queueVacant);
endmodule

// [verification/hsl_link_peer.sv]
`timescale 1ns/1ps
// far-side transmitter: one bit per clock, steady line level
module hsl_link_peer
(
	input wire logic clk,
	input wire logic level,
	output logic serialIn
);
	// one lane, clocked by the same clock as the receiver it feeds
	always_ff @(posedge clk)
	begin
		serialIn <= level;
	end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
`include "hsl_lane_regs.svh"
module tb;
	import hsl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	logic [9:0] txWord = 10'h0;
	logic txPathClear = 1'b0;
	logic driveOn = 1'b1;
	logic serialOut, serialOutN, serialOe, serialIn, termEnable;
	logic rxBufferOn = 1'b1;
	logic termControl = 1'b1;
	logic rxPathClear = 1'b0;
	logic [9:0] rxWord, queueData;
	logic delayAdjustOn = 1'b0;
	logic delayDirection = 1'b0;
	logic delayClear = 1'b0;
	logic alignLocked, queueVacant, wordTick, bitTick, bitClockOut;
	hsl_delay_t alignDelayReport;
	logic queueRead = 1'b0;
	logic peerLevel = 1'b0;
	int n_fail = 0;
	int checks = 0;
	int i;
	logic bc;

	always #12.5 clk = ~clk;

	hsl_lane dut_u (.clk, .reset, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .txWord, .txPathClear, .driveOn, .serialOut, .serialOutN,
		.serialOe, .serialIn, .rxBufferOn, .termControl, .termEnable,
		.rxPathClear, .rxWord, .delayAdjustOn, .delayDirection, .delayClear,
		.alignLocked, .alignDelayReport, .queueRead, .queueData, .queueVacant,
		.wordTick, .bitTick, .bitClockOut);

	hsl_link_peer peer_u (.clk, .level(peerLevel), .serialIn);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
	endtask

	// returns at the edge that takes a word tick
	task automatic waitWord;
		int k;
		for (k = 0; k < 40; k++)
		begin
			@(negedge clk);
			if (wordTick === 1'b1)
				break;
		end
		@(posedge clk);
	endtask

	// serial bits, lsb first, one per cycle after the load edge
	task automatic txChk(input logic [9:0] exp, input int n);
		int k;
		waitWord;
		for (k = 0; k < n; k++)
		begin
			#1 chk(serialOut, exp[k]);
			@(posedge clk);
		end
	endtask

	initial
	begin
		#(25 * 20000);
		n_fail++;
		print_verdict;
	end

	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		peerLevel <= 1'b1;
		rdChk(`HSL_CTRL_OFS, 32'h008);
		rdChk(4'hc, 32'h0);
		chk(queueVacant, 32'h1);
		txWord <= 10'h3a5;
		waitWord;
		txChk(10'h0a5, 8);
		wr(`HSL_CTRL_OFS, 32'h004);
		waitWord;
		txChk(10'h005, 4);
		wr(`HSL_CTRL_OFS, 32'h018);
		waitWord;
		txChk(10'h00f, 8);
		wr(`HSL_CTRL_OFS, 32'h008);
		txPathClear <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(serialOut, 32'h0);
		txPathClear <= 1'b0;
		driveOn <= 1'b0;
		@(posedge clk);
		#1 chk(serialOe, 32'h0);
		driveOn <= 1'b1;
		chk(termEnable, 32'h1);
		wr(`HSL_CTRL_OFS, 32'h808);
		termControl <= 1'b0;
		@(posedge clk);
		#1 chk(termEnable, 32'h0);
		wr(`HSL_CTRL_OFS, 32'h048);
		repeat (3) waitWord;
		#1 chk(rxWord, 32'h0ff);
		chk(queueVacant, 32'h0);
		@(posedge clk);
		queueRead <= 1'b1;
		@(posedge clk);
		queueRead <= 1'b0;
		#1 chk(queueData, 32'h0ff);
		rxBufferOn <= 1'b0;
		repeat (12) waitWord;
		#1 chk(rxWord, 32'h0);
		rxBufferOn <= 1'b1;
		rdChk(`HSL_STATUS_OFS, 32'h004);
		rxPathClear <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(queueVacant, 32'h1);
		chk(rxWord, 32'h0);
		rxPathClear <= 1'b0;
		wr(`HSL_CTRL_OFS, 32'h008);
		waitWord;
		delayDirection <= 1'b1;
		delayAdjustOn <= 1'b1;
		repeat (3) waitWord;
		delayAdjustOn <= 1'b0;
		rdChk(`HSL_DELAY_OFS, 32'h3);
		waitWord;
		delayDirection <= 1'b0;
		delayAdjustOn <= 1'b1;
		repeat (2) waitWord;
		delayAdjustOn <= 1'b0;
		rdChk(`HSL_DELAY_OFS, 32'h1);
		delayClear <= 1'b1;
		waitWord;
		delayClear <= 1'b0;
		rdChk(`HSL_DELAY_OFS, 32'h0);
		wr(`HSL_CTRL_OFS, 32'h028);
		delayAdjustOn <= 1'b1;
		waitWord;
		delayAdjustOn <= 1'b0;
		for (i = 0; i < 200; i++)
		begin
			@(negedge clk);
			if (alignLocked === 1'b1)
				break;
		end
		chk(alignLocked, 32'h1);
		chk(alignDelayReport, 32'h0);
		rdChk(`HSL_STATUS_OFS, 32'h003);
		delayClear <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(alignLocked, 32'h0);
		delayClear <= 1'b0;
		chk(bitClockOut, 32'h1);
		wr(`HSL_CTRL_OFS, 32'h088);
		@(posedge clk);
		#1 bc = bitClockOut;
		@(posedge clk);
		#1 chk(bitClockOut, {31'h0, ~bc});
		wr(`HSL_CTRL_OFS, 32'h100);
		txWord <= 10'h001;
		repeat (2) @(posedge clk);
		#1 chk(serialOut, 32'h1);
		print_verdict;
	end
endmodule
